/* rtl/tft_pkg.sv */
/*
 Shared constants and types for both ends of the display module host port.
 Assumes a 250 MHz system clock at the host and a link clock made from it.
*/
// Contract
// - Device takes bus activity only while selected; RGB pixels and frame pulses are taken unselected.
// - Select high means data, low means command.
// - Device changes serial output on serial clock falls.
// - Host captures read data at read strobe rise.
// - Host resets module before any use.
// - Shared 18-bit two-way bus, unused lines low.
// - Host supplies frame, line, enable and pixel clock.
// - Static straps; RGB use needs serial selection.
// - Store strobe: parallel write, four-line data select.
// - Frame is 240 by 320, 65K/262K colour.
// - Serial modes reuse select pin as serial clock.
package tft_pkg;
    localparam int DATA_W = 18;
    localparam int FIFO_W = 19;
    localparam int FIFO_DEPTH = 16;
    // Last column and row of the 240 by 320 frame.
    localparam logic [7:0] X_LAST = 8'hef;
    localparam logic [8:0] Y_LAST = 9'h13f;
    localparam logic [2:0] PICK_PAR = 3'h0;
    localparam logic [2:0] PICK_SER3 = 3'h5;
    localparam logic [2:0] PICK_SER4 = 3'h6;
    localparam logic [1:0] MODE_PAR = 2'h0;
    localparam logic [1:0] MODE_SER3 = 2'h1;
    localparam logic [1:0] MODE_SER4 = 2'h2;
    localparam logic [1:0] MODE_RGB = 2'h3;
    // Link clock is the system clock divided by eight.
    localparam logic [2:0] DIV_LAST = 3'h7;
    localparam int SYS_MHZ = 250;
    localparam int RST_HOLD_NS = 10000;
    localparam logic [11:0] RST_HOLD_CYC = 12'((RST_HOLD_NS * SYS_MHZ + 999) / 1000);
    localparam logic [6:0] PAR_WR_END = 7'h04;
    localparam logic [6:0] PAR_RD_CAP = 7'h05;
    localparam logic [6:0] PAR_RD_END = 7'h08;
    localparam logic [6:0] SER9_END = 7'h48;
    localparam logic [6:0] SER8_END = 7'h40;
    localparam logic [2:0] SER_BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        HS_RESET = 3'b000,
        HS_IDLE = 3'b001,
        HS_PWR = 3'b010,
        HS_PRD = 3'b011,
        HS_SER = 3'b100
    } tft_hstate_type;

    typedef struct packed {
        logic cs_n;
        logic dcs;
        logic wr;
        logic rd_n;
        logic sda;
        logic fp;
        logic lp;
        logic de;
        logic [2:0] pick;
        logic [DATA_W-1:0] bus;
    } tft_pins_type;
endpackage : tft_pkg

/* rtl/tft_bus_if.sv */
/*
 The pins between host and display module, with the shared data bus resolved.
 Assumes at most one party enables the bus at a time; host wins a clash.
*/
`timescale 1ns/100ps
`default_nettype none
interface tft_bus_if;
    logic pixel_tick;
    logic reset_n;
    logic chip_select_n;
    logic cmd_data_select;
    logic host_store_strobe;
    logic read_strobe_n;
    logic serial_in_line;
    logic serial_out_line;
    logic frame_pulse;
    logic line_pulse;
    logic data_en;
    logic interface_pick_2;
    logic interface_pick_1;
    logic interface_pick_0;
    logic [17:0] host_data;
    logic host_data_oe;
    logic [17:0] dev_data;
    logic dev_data_oe;
    logic [17:0] data_bus;

    // Undriven lines read low, as if tied to ground.
    assign data_bus = host_data_oe ? host_data : (dev_data_oe ? dev_data : 18'h0);

    modport host (
        output pixel_tick, reset_n, chip_select_n, cmd_data_select, host_store_strobe,
        output read_strobe_n, serial_in_line, frame_pulse, line_pulse, data_en,
        output interface_pick_2, interface_pick_1, interface_pick_0, host_data, host_data_oe,
        input serial_out_line, data_bus
    );
    modport dev (
        input pixel_tick, reset_n, chip_select_n, cmd_data_select, host_store_strobe,
        input read_strobe_n, serial_in_line, frame_pulse, line_pulse, data_en,
        input interface_pick_2, interface_pick_1, interface_pick_0, data_bus,
        output serial_out_line, dev_data, dev_data_oe
    );
endinterface : tft_bus_if
`default_nettype wire

/* rtl/tft_dev_end.sv */
/*
 Display module end: pin decoding for parallel, serial and RGB routes, a word
 FIFO and a pixel writer walking the frame. Runs wholly on the link clock.
 Assumes the host holds straps static and keeps the reset sequence.
*/
`timescale 1ns/100ps
`default_nettype none
module tft_fifo #(
    parameter int WIDTH = tft_pkg::FIFO_W,
    parameter int DEPTH = tft_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    import tft_pkg::*;
    // Depth must be a power of two so the pointers wrap on their own.
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tft_fifo_type;
    tft_fifo_type q;
    tft_fifo_type d;
    logic push;
    logic pop;

    assign in_ready_out = q.cnt != (AW+1)'(DEPTH);
    assign out_valid_out = q.cnt != '0;
    assign out_data_out = q.mem[q.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_in;
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : tft_fifo

module tft_dev_end (
    tft_bus_if.dev link_io,
    input wire logic depth_18_in,
    input wire logic pix_ready_in,
    output logic pix_valid_out,
    output logic [tft_pkg::DATA_W-1:0] pix_data_out,
    output logic [7:0] pix_x_out,
    output logic [8:0] pix_y_out,
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out,
    output logic drop_out
);
    import tft_pkg::*;
    typedef struct packed {
        tft_pins_type s1;
        tft_pins_type s2;
        tft_pins_type p;
        logic pv;
        logic [FIFO_W-1:0] pw;
        logic drop;
        logic [8:0] shi;
        logic [3:0] bc;
        logic [7:0] so;
        logic doe;
        logic [DATA_W-1:0] dout;
        logic [7:0] nx;
        logic [8:0] ny;
        logic ov;
        logic [DATA_W-1:0] pix;
        logic [7:0] x;
        logic [8:0] y;
        logic cv;
        logic [7:0] cmd;
    } tft_dev_type;
    tft_dev_type q;
    tft_dev_type d;
    tft_pins_type pins;
    logic f_ready;
    logic f_valid;
    logic [FIFO_W-1:0] f_data;
    logic take;

    assign pins = '{link_io.chip_select_n, link_io.cmd_data_select, link_io.host_store_strobe,
        link_io.read_strobe_n, link_io.serial_in_line, link_io.frame_pulse,
        link_io.line_pulse, link_io.data_en,
        {link_io.interface_pick_2, link_io.interface_pick_1, link_io.interface_pick_0},
        link_io.data_bus};
    assign take = f_valid && (!q.ov || pix_ready_in);

    tft_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) fifo_u (
        .clk_in(link_io.pixel_tick),
        .rst_b_in(link_io.reset_n),
        .in_valid_in(q.pv),
        .in_ready_out(f_ready),
        .in_data_in(q.pw),
        .out_valid_out(f_valid),
        .out_ready_in(take),
        .out_data_out(f_data)
    );

    always_comb begin
        logic sel;
        logic par;
        logic ser;
        logic ser3;
        logic nw;
        logic [FIFO_W-1:0] w;
        logic [DATA_W-1:0] col;
        sel = 1'b0;
        par = 1'b0;
        ser = 1'b0;
        ser3 = 1'b0;
        nw = 1'b0;
        w = '0;
        col = '0;
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.p = q.s2;
        d.cv = 1'b0;
        sel = !q.s2.cs_n;
        par = q.s2.pick == PICK_PAR;
        ser3 = q.s2.pick == PICK_SER3;
        ser = ser3 || (q.s2.pick == PICK_SER4);
        if (par && sel && q.s2.wr && !q.p.wr) begin
            nw = 1'b1;
            w = {q.s2.dcs, q.s2.bus};
        end
        d.doe = par && sel && !q.s2.rd_n;
        d.dout = {q.drop, q.ny, q.nx};
        if (!sel) begin
            d.bc = '0;
            // Reloading only under a serial strap keeps the line still through parallel cycles.
            if (ser) begin
                d.so = q.cmd;
            end
        end else if (ser && q.s2.dcs && !q.p.dcs && q.s2.rd_n) begin
            d.shi = {q.shi[7:0], q.s2.sda};
            d.bc = q.bc + 1'b1;
            if (ser3 && q.bc == 4'h8) begin
                nw = 1'b1;
                w = {d.shi[8], 10'h0, d.shi[7:0]};
                d.bc = '0;
            end else if (!ser3 && q.bc == 4'h7) begin
                nw = 1'b1;
                w = {q.s2.wr, 10'h0, d.shi[7:0]};
                d.bc = '0;
            end
        end else if (ser && !q.s2.dcs && q.p.dcs) begin
            d.so = {q.so[6:0], 1'b0};
        end
        // RGB pixels are taken only with a serial strap, on every pixel tick with data enable high and no rising frame pulse.
        if (ser && q.s2.fp && !q.p.fp) begin
            nw = 1'b1;
            w = '0;
        end else if (ser && q.s2.de) begin
            nw = 1'b1;
            w = {1'b1, q.s2.bus};
        end
        // A word is held until the FIFO takes it; one arriving meanwhile is lost.
        if (q.pv && f_ready) begin
            d.pv = 1'b0;
        end
        if (nw) begin
            if (d.pv) begin
                d.drop = 1'b1;
            end else begin
                d.pv = 1'b1;
                d.pw = w;
            end
        end
        if (pix_ready_in) begin
            d.ov = 1'b0;
        end
        col = depth_18_in ? f_data[DATA_W-1:0] :
            {f_data[15:11], f_data[15], f_data[10:5], f_data[4:0], f_data[4]};
        if (take) begin
            if (f_data[FIFO_W-1]) begin
                d.ov = 1'b1;
                d.pix = col;
                d.x = q.nx;
                d.y = q.ny;
                d.nx = (q.nx == X_LAST) ? 8'h0 : q.nx + 8'h1;
                if (q.nx == X_LAST) begin
                    d.ny = (q.ny == Y_LAST) ? 9'h0 : q.ny + 9'h1;
                end
            end else begin
                // Any command restarts the write position at the frame origin.
                d.cv = 1'b1;
                d.cmd = f_data[7:0];
                d.nx = 8'h0;
                d.ny = 9'h0;
            end
        end
    end

    always_ff @(posedge link_io.pixel_tick or negedge link_io.reset_n) begin
        if (!link_io.reset_n) begin
            q <= '0;
            q.s1.cs_n <= 1'b1;
            q.s2.cs_n <= 1'b1;
            q.p.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link_io.serial_out_line = q.so[7];
    assign link_io.dev_data = q.dout;
    assign link_io.dev_data_oe = q.doe;
    assign pix_valid_out = q.ov;
    assign pix_data_out = q.pix;
    assign pix_x_out = q.x;
    assign pix_y_out = q.y;
    assign cmd_valid_out = q.cv;
    assign cmd_code_out = q.cmd;
    assign drop_out = q.drop;
endmodule : tft_dev_end
`default_nettype wire

/* rtl/tft_host_end.sv */
/*
 Host end: makes the link clock and module reset, runs parallel and serial
 transfers for a request port and streams RGB pixels with frame and line sync.
 Assumes mode_in changes only while no transfer is in flight.
*/
`timescale 1ns/100ps
`default_nettype none
module tft_host_end (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    tft_bus_if.host link_io,
    input wire logic [1:0] mode_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_dc_in,
    input wire logic req_read_in,
    input wire logic [tft_pkg::DATA_W-1:0] req_word_in,
    output logic rsp_valid_out,
    output logic [tft_pkg::DATA_W-1:0] rsp_word_out,
    input wire logic pix_valid_in,
    output logic pix_ready_out,
    input wire logic [tft_pkg::DATA_W-1:0] pix_word_in,
    output logic link_up_out
);
    import tft_pkg::*;
    typedef struct packed {
        logic [2:0] div;
        logic lclk;
        logic [11:0] rcnt;
        logic prst_n;
        logic up;
        tft_hstate_type st;
        logic [6:0] step;
        logic [6:0] last;
        logic cs_n;
        logic dcs;
        logic wr;
        logic rd_n;
        logic sda;
        logic fp;
        logic lp;
        logic de;
        logic [2:0] pick;
        logic [DATA_W-1:0] hd;
        logic hoe;
        logic [DATA_W:0] s1;
        logic [DATA_W:0] s2;
        logic rq_rdy;
        logic rq_dc;
        logic rq_rd;
        logic [DATA_W-1:0] rq_w;
        logic [8:0] sh;
        logic rs_v;
        logic [DATA_W-1:0] rs_w;
        logic px_rdy;
        logic pb_v;
        logic [DATA_W-1:0] pb;
        logic [7:0] hx;
        logic [8:0] hy;
        logic synced;
    } tft_host_type;
    tft_host_type q;
    tft_host_type d;

    always_comb begin
        logic tick;
        logic ser3;
        logic [6:0] ns;
        tick = 1'b0;
        ser3 = 1'b0;
        ns = '0;
        d = q;
        // Pins other than reset and straps change only as the divided link clock falls; the module samples on its rise.
        d.div = q.div + 3'h1;
        d.lclk = d.div[2];
        tick = q.div == DIV_LAST;
        ns = q.step + 7'h1;
        d.s1 = {link_io.serial_out_line, link_io.data_bus};
        d.s2 = q.s1;
        d.rs_v = 1'b0;
        ser3 = mode_in == MODE_SER3;
        case (mode_in)
            MODE_PAR: begin
                d.pick = PICK_PAR;
            end
            MODE_SER3: begin
                d.pick = PICK_SER3;
            end
            default: begin
                d.pick = PICK_SER4;
            end
        endcase
        if (req_valid_in && q.rq_rdy) begin
            d.rq_rdy = 1'b0;
            d.rq_dc = req_dc_in;
            d.rq_rd = req_read_in;
            d.rq_w = req_word_in;
        end
        if (pix_valid_in && q.px_rdy) begin
            d.px_rdy = 1'b0;
            d.pb_v = 1'b1;
            d.pb = pix_word_in;
        end
        case (q.st)
            HS_RESET: begin
                // The module is held in reset for a fixed time before any request.
                d.prst_n = 1'b0;
                d.rcnt = q.rcnt + 12'h1;
                if (q.rcnt == RST_HOLD_CYC) begin
                    d.prst_n = 1'b1;
                    d.up = 1'b1;
                    d.rq_rdy = 1'b1;
                    d.px_rdy = 1'b1;
                    d.st = HS_IDLE;
                end
            end
            HS_IDLE: begin
                if (tick) begin
                    d.fp = 1'b0;
                    d.lp = 1'b0;
                    d.de = 1'b0;
                    d.hoe = 1'b0;
                    d.step = 7'h0;
                    if (!q.rq_rdy) begin
                        d.cs_n = 1'b0;
                        if (mode_in == MODE_PAR) begin
                            if (q.rq_rd) begin
                                d.rd_n = 1'b0;
                                d.st = HS_PRD;
                            end else begin
                                d.dcs = q.rq_dc;
                                d.hd = q.rq_w;
                                d.hoe = 1'b1;
                                d.wr = 1'b0;
                                d.st = HS_PWR;
                            end
                        end else begin
                            // Serial reads hold the read strobe low so the bits are not taken as a word.
                            d.dcs = 1'b0;
                            d.rd_n = !q.rq_rd;
                            d.wr = q.rq_dc;
                            d.sh = q.rq_rd ? 9'h0 :
                                (ser3 ? {q.rq_dc, q.rq_w[7:0]} : {q.rq_w[7:0], 1'b0});
                            d.sda = d.sh[8];
                            d.last = (ser3 && !q.rq_rd) ? SER9_END : SER8_END;
                            d.rs_w = '0;
                            d.st = HS_SER;
                        end
                    end else if (mode_in == MODE_RGB && q.pb_v) begin
                        if (q.hx == 8'h0 && !q.synced) begin
                            // One sync tick without data opens every line; frame sync joins the first.
                            d.lp = 1'b1;
                            d.fp = q.hy == 9'h0;
                            d.synced = 1'b1;
                        end else begin
                            d.de = 1'b1;
                            d.hd = q.pb;
                            d.hoe = 1'b1;
                            d.pb_v = 1'b0;
                            d.px_rdy = 1'b1;
                            d.hx = (q.hx == X_LAST) ? 8'h0 : q.hx + 8'h1;
                            if (q.hx == X_LAST) begin
                                d.synced = 1'b0;
                                d.hy = (q.hy == Y_LAST) ? 9'h0 : q.hy + 9'h1;
                            end
                        end
                    end
                end
            end
            HS_PWR: begin
                if (tick) begin
                    d.step = ns;
                    if (q.step == 7'h0) begin
                        d.wr = 1'b1;
                    end
                    if (q.step == PAR_WR_END) begin
                        d.cs_n = 1'b1;
                        d.hoe = 1'b0;
                        d.rq_rdy = 1'b1;
                        d.st = HS_IDLE;
                    end
                end
            end
            HS_PRD: begin
                if (tick) begin
                    d.step = ns;
                    if (q.step == PAR_RD_CAP) begin
                        d.rd_n = 1'b1;
                        d.rs_w = q.s2[DATA_W-1:0];
                        d.rs_v = 1'b1;
                    end
                    if (q.step == PAR_RD_END) begin
                        d.cs_n = 1'b1;
                        d.rq_rdy = 1'b1;
                        d.st = HS_IDLE;
                    end
                end
            end
            HS_SER: begin
                if (tick) begin
                    d.step = ns;
                    d.dcs = ns[2];
                    if (q.step[2:0] == SER_BIT_LAST) begin
                        // Sampled just before the fall, after the module's change has settled.
                        d.sh = {q.sh[7:0], 1'b0};
                        d.rs_w = {q.rs_w[DATA_W-2:0], q.s2[DATA_W]};
                    end
                    d.sda = d.sh[8];
                    if (ns == q.last) begin
                        d.cs_n = 1'b1;
                        d.dcs = 1'b0;
                        d.rd_n = 1'b1;
                        d.rs_v = q.rq_rd;
                        d.rq_rdy = 1'b1;
                        d.st = HS_IDLE;
                    end
                end
            end
            default: begin
                d.st = HS_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
            q.cs_n <= 1'b1;
            q.rd_n <= 1'b1;
            q.wr <= 1'b1;
            q.st <= HS_RESET;
        end else begin
            q <= d;
        end
    end

    assign link_io.pixel_tick = q.lclk;
    assign link_io.reset_n = q.prst_n;
    assign link_io.chip_select_n = q.cs_n;
    assign link_io.cmd_data_select = q.dcs;
    assign link_io.host_store_strobe = q.wr;
    assign link_io.read_strobe_n = q.rd_n;
    assign link_io.serial_in_line = q.sda;
    assign link_io.frame_pulse = q.fp;
    assign link_io.line_pulse = q.lp;
    assign link_io.data_en = q.de;
    assign link_io.interface_pick_2 = q.pick[2];
    assign link_io.interface_pick_1 = q.pick[1];
    assign link_io.interface_pick_0 = q.pick[0];
    assign link_io.host_data = q.hd;
    assign link_io.host_data_oe = q.hoe;
    assign req_ready_out = q.rq_rdy;
    assign rsp_valid_out = q.rs_v;
    assign rsp_word_out = q.rs_w;
    assign pix_ready_out = q.px_rdy;
    assign link_up_out = q.up;
endmodule : tft_host_end
`default_nettype wire

/* test/tft_port_asserts.sv */
/*
 Assertions on the pins between the host end and the display end.
 Assumes every pin changes only on system clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
module tft_port_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic cmd_data_select,
    input wire logic host_store_strobe,
    input wire logic read_strobe_n,
    input wire logic serial_out_line,
    input wire logic line_pulse,
    input wire logic data_en,
    input wire logic host_data_oe,
    input wire logic dev_data_oe
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    property p_oe_sel; $rose(dev_data_oe) |-> !chip_select_n && !read_strobe_n; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("bus driven unselected");
    property p_one_drv; !(host_data_oe && dev_data_oe); endproperty
    a_one_drv: assert property (p_one_drv) else $error("bus clash");
    property p_rd_free; !read_strobe_n |-> !host_data_oe; endproperty
    a_rd_free: assert property (p_rd_free) else $error("host drives in read");
    property p_sdo_edge; !chip_select_n && $changed(serial_out_line) |-> !cmd_data_select;
    endproperty
    a_sdo_edge: assert property (p_sdo_edge) else $error("serial out moved");
    property p_wr_sel; $fell(host_store_strobe) |-> !chip_select_n; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("strobe unselected");
    property p_rd_sel; $fell(read_strobe_n) |-> !chip_select_n; endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read unselected");
    property p_rst_idle; !reset_n |-> chip_select_n; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("select in reset");
    property p_line_gap; line_pulse |-> !data_en; endproperty
    a_line_gap: assert property (p_line_gap) else $error("pixel in line sync");
    cover property ($rose(dev_data_oe));
    cover property ($fell(host_store_strobe));
    cover property ($rose(line_pulse));
endmodule : tft_port_asserts
`default_nettype wire

/* test/tft_module_host_interface_tb.sv */
/*
 Bench joining the host end and the display end through the pin interface.
 Assumes the package reset hold; the display end runs on the host's link clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tft_module_host_interface_tb;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, rq_v = 1'b0, rq_dc = 1'b0, rq_rd = 1'b0;
    logic px_v = 1'b0, px_rdy = 1'b0, stall = 1'b0, pr, rq_rdy, rs_v, px_rdy_h, link_up, pv, cv;
    logic drop, d18 = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [17:0] rq_w = 18'h00000, px_w = 18'h00000, rs_w, pd, w;
    logic [7:0] px, cc, c;
    logic [8:0] py;
    logic [34:0] pq[$], eq[$];
    logic [7:0] cq[$];
    int miscompares = 0, checks_done = 0, cyc = 0;
    tft_bus_if tft_bus_if_i ();
    tft_host_end tft_host_end_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .link_io(tft_bus_if_i), .mode_in(mode), .req_valid_in(rq_v), .req_ready_out(rq_rdy),
        .req_dc_in(rq_dc), .req_read_in(rq_rd), .req_word_in(rq_w), .rsp_valid_out(rs_v),
        .rsp_word_out(rs_w), .pix_valid_in(px_v), .pix_ready_out(px_rdy_h),
        .pix_word_in(px_w), .link_up_out(link_up));
    tft_dev_end tft_dev_end_i (.link_io(tft_bus_if_i), .depth_18_in(d18), .pix_ready_in(px_rdy),
        .pix_valid_out(pv), .pix_data_out(pd), .pix_x_out(px), .pix_y_out(py),
        .cmd_valid_out(cv), .cmd_code_out(cc), .drop_out(drop));
    tft_port_asserts tft_port_asserts_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .reset_n(tft_bus_if_i.reset_n), .chip_select_n(tft_bus_if_i.chip_select_n),
        .cmd_data_select(tft_bus_if_i.cmd_data_select), .data_en(tft_bus_if_i.data_en),
        .host_store_strobe(tft_bus_if_i.host_store_strobe),
        .read_strobe_n(tft_bus_if_i.read_strobe_n), .line_pulse(tft_bus_if_i.line_pulse),
        .serial_out_line(tft_bus_if_i.serial_out_line),
        .host_data_oe(tft_bus_if_i.host_data_oe), .dev_data_oe(tft_bus_if_i.dev_data_oe));

    initial begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // RGB mode streams a word every tick, so stalling there would only overflow the buffer.
    always @(negedge tft_bus_if_i.pixel_tick) begin
        pr = !stall && (mode == 2'h3 || $urandom_range(3) != 0);
        if (pv === 1'b1 && pr) begin
            pq.push_back({pd, px, py});
        end
        // A command restarts the frame position, so pixel bookkeeping restarts too.
        if (cv === 1'b1) begin
            cq.push_back(cc);
            pq.delete();
        end
        px_rdy = pr;
    end

    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [34:0] exp_pix(input logic [17:0] v, input int i);
        return {d18 ? v : {v[15:11], v[15], v[10:5], v[4:0], v[4]}, 8'(i % 240), 9'(i / 240)};
    endfunction : exp_pix

    task automatic req(input logic dc, input logic rd, input logic [17:0] v);
        while (rq_rdy !== 1'b1) @(negedge sys_clk_in);
        rq_v = 1'b1;
        rq_dc = dc;
        rq_rd = rd;
        rq_w = v;
        @(negedge sys_clk_in);
        rq_v = 1'b0;
        while (rd && rs_v !== 1'b1) @(negedge sys_clk_in);
        while (rq_rdy !== 1'b1) @(negedge sys_clk_in);
    endtask : req

    task automatic send(input int n);
        logic [17:0] v;
        for (int i = 0; i < n; i++) begin
            v = 18'($urandom);
            eq.push_back(exp_pix(v, i));
            req(1'b1, 1'b0, v);
        end
    endtask : send

    task automatic drain(input int n);
        while (pq.size() < n) @(negedge sys_clk_in);
        repeat (n) check("pixel", pq.pop_front(), eq.pop_front());
    endtask : drain

    initial begin
        void'($urandom(42133));
        repeat (10) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        @(negedge sys_clk_in);
        check("module reset", tft_bus_if_i.reset_n, 1'b0);
        while (rq_rdy !== 1'b1) @(negedge sys_clk_in);
        check("link up", {link_up, tft_bus_if_i.reset_n}, 2'h3);
        for (int m = 0; m < 3; m++) begin
            mode = 2'(m);
            c = 8'($urandom);
            req(1'b0, 1'b0, {10'h000, c});
            while (cq.size() == 0) @(negedge sys_clk_in);
            check("command", cq.pop_front(), c);
            if (m == 0) begin
                send(5);
                drain(5);
            end
            req(1'b0, 1'b1, 18'h00000);
            if (m == 0) check("status", rs_w, 18'h00005);
            else check("serial read", rs_w, {10'h000, c});
            $display("test mode %0d done", m);
        end
        mode = 2'h0;
        d18 = 1'b0;
        stall = 1'b1;
        req(1'b0, 1'b0, 18'h00000);
        send(24);
        check("overflow", drop, 1'b1);
        stall = 1'b0;
        drain(16);
        eq.delete();
        cq.delete();
        $display("test buffer fill done");
        mode = 2'h3;
        for (int i = 0; i < 242; i++) begin
            w = 18'($urandom);
            eq.push_back(exp_pix(w, i));
            while (px_rdy_h !== 1'b1) @(negedge sys_clk_in);
            px_w = w;
            px_v = 1'b1;
            @(negedge sys_clk_in);
            px_v = 1'b0;
        end
        while (cq.size() == 0) @(negedge sys_clk_in);
        check("frame command", cq.pop_front(), 8'h00);
        drain(242);
        check("rgb strap", {tft_bus_if_i.interface_pick_2, tft_bus_if_i.interface_pick_1,
            tft_bus_if_i.interface_pick_0}, 3'h6);
        $display("test rgb done");
        report_and_stop();
    end
endmodule : tft_module_host_interface_tb
`default_nettype wire
